// *** logic/ipc_cfg.svh ***
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
// ****************************************************************
// command word layout, bit 15 of the word is the msb
// ****************************************************************
`define IPC_CW_DC      15
`define IPC_CW_COND    11
`define IPC_CW_ORD     14:12
`define IPC_CW_CNT     11:0
`define IPC_CW_TOP     15:12
`define IPC_ORD_JUMP   3'h0
`define IPC_ORD_RESID  3'h1
`define IPC_ORD_INTR   3'h2
`define IPC_ORD_END    3'h3
`define IPC_ORD_CTRL   3'h4
`define IPC_ORD_SENSE  3'h5
`define IPC_ORD_WRITE  3'h6
`define IPC_ORD_READ   3'h7
`define IPC_CNT_ONE    12'h001
`define IPC_CNT_ZERO   12'h000
`define IPC_RES_PAD    4'h0
`define IPC_PW_STEP    16'h0002
`define IPC_AW_STEP    16'h0001
`define IPC_DRT_PAD    10'h000
`define IPC_DRT_LOW    2'h0
`define IPC_NDEV       16
`define IPC_ONE_HOT    16'h0001
// ****************************************************************
// direct instruction codes
// ****************************************************************
`define IPC_DOP_READ   3'h0
`define IPC_DOP_WRITE  3'h1
`define IPC_DOP_TEST   3'h2
`define IPC_DOP_CTRL   3'h3
`define IPC_DOP_SETINT 3'h4
`define IPC_DOP_SETMSK 3'h5
`define IPC_DOP_START  3'h6
// ****************************************************************
// register map
// ****************************************************************
`define IPC_REG_DIO    4'h0
`define IPC_REG_DDATA  4'h1
`define IPC_REG_PEND   4'h2
`define IPC_REG_MASK   4'h3
`define IPC_REG_SELDEV 4'h4
`define IPC_REG_RUN    4'h5
`define IPC_DIO_OP     6:4
`define IPC_DIO_DEV    3:0
`define IPC_ST_PAD     13'h0000
`define IPC_SELDEV_PAD 12'h000
`define IPC_RST_WORD   16'h0000
`define IPC_RST_DEV    4'h0
`endif

// *** logic/ipc_channel.sv ***
`include "ipc_cfg.svh"
module ipc_channel (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              ce,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    output logic                   cpu_irq,
    output logic [3:0]             cpu_irq_dev,
    input  wire logic [15:0]       dev_irq,
    output ipc_pkg::ipc_dio_s      dio_o,
    input  wire logic              dio_ack,
    input  wire logic [15:0]       dio_rdata,
    output ipc_pkg::ipc_mreq_s     iop_mem_o,
    input  wire logic              iop_mem_gnt,
    input  wire logic [15:0]       iop_mem_rdata,
    input  wire logic [15:0]       mx_srv_req,
    output ipc_pkg::ipc_ord_s      mx_o,
    input  wire ipc_pkg::ipc_dvi_s mx_i,
    output ipc_pkg::ipc_mreq_s     sl_mem_o,
    input  wire logic              sl_mem_gnt,
    input  wire logic [15:0]       sl_mem_rdata,
    input  wire logic              sl_srv_req,
    output ipc_pkg::ipc_ord_s      sl_o,
    input  wire ipc_pkg::ipc_dvi_s sl_i
);
    import ipc_pkg::*;

    // ****************************************************************
    // order decode shared by both channels
    // ****************************************************************
    function automatic ipc_act_s exec_f(
        input logic [15:0] cw,
        input logic [15:0] aw,
        input logic [15:0] loc,
        input logic [15:0] drt,
        input ipc_dvi_s    di,
        input logic        mux
    );
        ipc_act_s    a;
        logic [11:0] nc;
        logic        ex;
        a = '0;
        nc = cw[`IPC_CW_CNT] + `IPC_CNT_ONE;
        ex = (nc == `IPC_CNT_ZERO);
        a.cnt = nc;
        a.dstb = 1'b1;
        a.refetch = 1'b1;
        a.last = 1'b1;
        case (cw[`IPC_CW_ORD])
            `IPC_ORD_JUMP: begin
                // jump target is the address word; the controller may refuse it
                if (!cw[`IPC_CW_COND] || di.jump_ok) begin
                    a.jmp = 1'b1;
                    a.mem = mux;
                    a.we = 1'b1;
                    a.addr = drt;
                    a.wdata = aw;
                end
            end
            `IPC_ORD_RESID: begin
                a.mem = 1'b1;
                a.we = 1'b1;
                a.addr = loc;
                a.wdata = {`IPC_RES_PAD, cw[`IPC_CW_CNT]};
            end
            `IPC_ORD_END: begin
                a.mem = 1'b1;
                a.we = 1'b1;
                a.addr = loc;
                a.wdata = di.status;
                a.fin = 1'b1;
            end
            `IPC_ORD_SENSE: begin
                a.mem = 1'b1;
                a.we = 1'b1;
                a.addr = loc;
                a.wdata = di.status;
            end
            `IPC_ORD_WRITE: begin
                // device strobe waits for the memory word
                a.mem = 1'b1;
                a.addr = aw;
                a.dstb = 1'b0;
                a.refetch = ex;
                a.last = ex && !cw[`IPC_CW_DC];
            end
            `IPC_ORD_READ: begin
                a.mem = 1'b1;
                a.we = 1'b1;
                a.addr = aw;
                a.wdata = di.data;
                a.refetch = ex;
                a.last = ex && !cw[`IPC_CW_DC];
            end
            default: begin
                // interrupt and control only strobe the controller
                a.dstb = 1'b1;
            end
        endcase
        return a;
    endfunction

    // ****************************************************************
    // register decode
    // ****************************************************************
    logic [15:0] ddata_q, mask_q, pend_q, run_q, vld_q, rdata_q, rd_val;
    logic [3:0]  seldev_q, irq_dev_q, irq_idx;
    logic        dbusy_q, irq_q, irq_any;
    ipc_dio_s    dio_q;
    ipc_mx_e     mx_st_q;
    ipc_sl_e     sl_st_q;
    wire         wr_dio = reg_wr && (reg_addr == `IPC_REG_DIO);
    wire         wr_dd = reg_wr && (reg_addr == `IPC_REG_DDATA);
    wire         wr_pend = reg_wr && (reg_addr == `IPC_REG_PEND);
    wire         wr_sdev = reg_wr && (reg_addr == `IPC_REG_SELDEV);
    wire [2:0]   go_op = reg_wdata[`IPC_DIO_OP];
    wire [3:0]   go_dev = reg_wdata[`IPC_DIO_DEV];
    wire         dio_go = wr_dio && !dbusy_q; // refused while busy
    wire         go_st = dio_go && (go_op == `IPC_DOP_START);
    wire         st_sel = go_st && (go_dev == seldev_q) && (sl_st_q == SL_IDLE);
    wire         st_mx = go_st && (go_dev != seldev_q);
    wire [15:0]  dev_bit = `IPC_ONE_HOT << go_dev;
    wire         cap_rd = dbusy_q && dio_ack &&
                          ((dio_q.op == `IPC_DOP_READ) || (dio_q.op == `IPC_DOP_TEST));
    wire [15:0]  stat_w = {`IPC_ST_PAD, mx_st_q != MX_IDLE, sl_st_q != SL_IDLE, dbusy_q};

    // read mux, unmapped offsets read zero
    assign rd_val = (reg_addr == `IPC_REG_DIO)    ? stat_w :
                    (reg_addr == `IPC_REG_DDATA)  ? ddata_q :
                    (reg_addr == `IPC_REG_PEND)   ? pend_q :
                    (reg_addr == `IPC_REG_MASK)   ? mask_q :
                    (reg_addr == `IPC_REG_SELDEV) ? {`IPC_SELDEV_PAD, seldev_q} :
                    (reg_addr == `IPC_REG_RUN)    ? run_q : `IPC_RST_WORD;
    assign reg_rdata = rdata_q;
    assign dio_o = dio_q;

    // ****************************************************************
    // direct instructions
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            dio_q <= '0;
            dbusy_q <= 1'b0;
            ddata_q <= `IPC_RST_WORD;
            mask_q <= `IPC_RST_WORD;
            seldev_q <= `IPC_RST_DEV;
            rdata_q <= `IPC_RST_WORD;
        end else if (ce) begin
            rdata_q <= reg_rd ? rd_val : `IPC_RST_WORD;
            dio_q.stb <= dio_go;
            if (dio_go) begin
                dio_q.op <= go_op;
                dio_q.dev <= go_dev;
                dio_q.data <= ddata_q;
            end
            // busy until the controller acknowledges
            if (dio_go)
                dbusy_q <= 1'b1;
            else if (dio_ack)
                dbusy_q <= 1'b0;
            if (wr_dd)
                ddata_q <= reg_wdata;
            else if (cap_rd)
                ddata_q <= dio_rdata;
            if (dio_go && (go_op == `IPC_DOP_SETMSK))
                mask_q <= ddata_q;
            if (wr_sdev)
                seldev_q <= reg_wdata[`IPC_DIO_DEV];
        end
    end

    // ****************************************************************
    // cpu interrupt on behalf of controllers
    // ****************************************************************
    ipc_prio u_irq_prio (
        .req (pend_q & mask_q),
        .any (irq_any),
        .idx (irq_idx)
    );
    assign cpu_irq = irq_q;
    assign cpu_irq_dev = irq_dev_q;

    // a new request wins over a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pend_q <= `IPC_RST_WORD;
            irq_q <= 1'b0;
            irq_dev_q <= `IPC_RST_DEV;
        end else if (ce) begin
            pend_q <= (pend_q & ~(wr_pend ? reg_wdata : `IPC_RST_WORD)) | dev_irq |
                      ((dio_go && (go_op == `IPC_DOP_SETINT)) ? dev_bit : `IPC_RST_WORD);
            irq_q <= irq_any;
            irq_dev_q <= irq_idx;
        end
    end

    // ****************************************************************
    // multiplexer channel
    // ****************************************************************
    logic [15:0] pw_cw_q [`IPC_NDEV];
    logic [15:0] pw_aw_q [`IPC_NDEV];
    logic [15:0] pw_loc_q [`IPC_NDEV];
    logic [15:0] mx_cw_q, mx_aw_q, mx_loc_q, mx_ptr_q, ma_q, mw_q;
    logic [3:0]  mx_dev_q, mx_idx;
    logic        mwe_q, mx_any;
    ipc_act_s    mx_act_q, mx_a;
    ipc_ord_s    mx_o_q;
    wire [15:0]  mx_drt = {`IPC_DRT_PAD, mx_dev_q, `IPC_DRT_LOW};
    wire         mx_acc = (mx_st_q == MX_PTR) || (mx_st_q == MX_CMD) ||
                          (mx_st_q == MX_ADW) || (mx_st_q == MX_PUPD) ||
                          (mx_st_q == MX_MEM);
    wire         mx_g = mx_acc && iop_mem_gnt;

    ipc_prio u_mx_prio (
        .req (mx_srv_req & run_q),
        .any (mx_any),
        .idx (mx_idx)
    );
    assign mx_a = exec_f(mx_cw_q, mx_aw_q, mx_loc_q, mx_drt, mx_i, 1'b1);
    assign iop_mem_o = {mx_acc, mwe_q, ma_q, mw_q};
    assign mx_o = mx_o_q;

    // one word per grant, then back to arbitration
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mx_st_q <= MX_IDLE;
            mx_dev_q <= `IPC_RST_DEV;
            {mx_cw_q, mx_aw_q, mx_loc_q, mx_ptr_q} <= '0;
            {ma_q, mw_q, mwe_q} <= '0;
            mx_act_q <= '0;
            mx_o_q <= '0;
        end else if (ce) begin
            mx_o_q.stb <= 1'b0;
            case (mx_st_q)
                MX_IDLE: if (mx_any) begin
                    mx_dev_q <= mx_idx;
                    mx_cw_q <= pw_cw_q[mx_idx];
                    mx_aw_q <= pw_aw_q[mx_idx];
                    mx_loc_q <= pw_loc_q[mx_idx];
                    ma_q <= {`IPC_DRT_PAD, mx_idx, `IPC_DRT_LOW};
                    mwe_q <= 1'b0;
                    mx_st_q <= vld_q[mx_idx] ? MX_EXEC : MX_PTR;
                end
                MX_PTR: if (mx_g) begin
                    mx_ptr_q <= iop_mem_rdata;
                    ma_q <= iop_mem_rdata;
                    mx_st_q <= MX_CMD;
                end
                MX_CMD: if (mx_g) begin
                    mx_cw_q <= iop_mem_rdata;
                    ma_q <= mx_ptr_q + `IPC_AW_STEP;
                    mx_st_q <= MX_ADW;
                end
                MX_ADW: if (mx_g) begin
                    mx_aw_q <= iop_mem_rdata;
                    mx_loc_q <= ma_q;
                    ma_q <= mx_drt;
                    mw_q <= mx_ptr_q + `IPC_PW_STEP;
                    mwe_q <= 1'b1;
                    mx_st_q <= MX_PUPD;
                end
                MX_PUPD: if (mx_g) begin
                    mwe_q <= 1'b0;
                    mx_st_q <= MX_EXEC;
                end
                MX_EXEC: begin
                    mx_act_q <= mx_a;
                    mx_o_q <= {mx_a.dstb, mx_dev_q, mx_cw_q[`IPC_CW_ORD],
                               mx_cw_q[`IPC_CW_CNT], mx_aw_q, mx_a.last};
                    ma_q <= mx_a.addr;
                    mw_q <= mx_a.wdata;
                    mwe_q <= mx_a.we;
                    mx_st_q <= mx_a.mem ? MX_MEM : MX_FIN;
                end
                MX_MEM: if (mx_g) begin
                    mwe_q <= 1'b0;
                    if (mx_cw_q[`IPC_CW_ORD] == `IPC_ORD_WRITE)
                        mx_o_q <= {1'b1, mx_dev_q, mx_cw_q[`IPC_CW_ORD],
                                   mx_cw_q[`IPC_CW_CNT], iop_mem_rdata, mx_act_q.last};
                    mx_st_q <= MX_FIN;
                end
                default: mx_st_q <= MX_IDLE;
            endcase
        end
    end

    // storage array write-back after each step
    always_ff @(posedge mclk) begin
        if (ce && (mx_st_q == MX_FIN)) begin
            pw_cw_q[mx_dev_q] <= {mx_cw_q[`IPC_CW_TOP], mx_act_q.cnt};
            pw_aw_q[mx_dev_q] <= mx_aw_q + `IPC_AW_STEP;
            pw_loc_q[mx_dev_q] <= mx_loc_q;
        end
    end

    // valid and running flags; a start wins over the step end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            vld_q <= `IPC_RST_WORD;
            run_q <= `IPC_RST_WORD;
        end else if (ce) begin
            if (mx_st_q == MX_FIN) begin
                vld_q[mx_dev_q] <= !(mx_act_q.refetch || mx_act_q.jmp);
                if (mx_act_q.fin)
                    run_q[mx_dev_q] <= 1'b0;
            end
            // per-bit, so a step end of another device in this cycle is kept
            if (st_mx) begin
                run_q[go_dev] <= 1'b1;
                vld_q[go_dev] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // selector channel, its own memory port
    // ****************************************************************
    logic [15:0] sl_cw_q, sl_aw_q, sl_loc_q, sl_ptr_q, sa_q, sw_q;
    logic        swe_q;
    ipc_act_s    sl_act_q, sl_a;
    ipc_ord_s    sl_o_q;
    wire [15:0]  sl_drt = {`IPC_DRT_PAD, seldev_q, `IPC_DRT_LOW};
    wire         sl_acc = (sl_st_q == SL_PTR) || (sl_st_q == SL_CMD) ||
                          (sl_st_q == SL_ADW) || (sl_st_q == SL_MEM) ||
                          (sl_st_q == SL_PTRW);
    wire         sl_g = sl_acc && sl_mem_gnt;

    assign sl_a = exec_f(sl_cw_q, sl_aw_q, sl_loc_q, sl_drt, sl_i, 1'b0);
    assign sl_mem_o = {sl_acc, swe_q, sa_q, sw_q};
    assign sl_o = sl_o_q;

    // dedicated to one controller from start until the end order
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sl_st_q <= SL_IDLE;
            {sl_cw_q, sl_aw_q, sl_loc_q, sl_ptr_q} <= '0;
            {sa_q, sw_q, swe_q} <= '0;
            sl_act_q <= '0;
            sl_o_q <= '0;
        end else if (ce) begin
            sl_o_q.stb <= 1'b0;
            case (sl_st_q)
                SL_IDLE: if (st_sel) begin
                    sa_q <= sl_drt;
                    swe_q <= 1'b0;
                    sl_st_q <= SL_PTR;
                end
                SL_PTR: if (sl_g) begin
                    sl_ptr_q <= sl_mem_rdata;
                    sa_q <= sl_mem_rdata;
                    sl_st_q <= SL_CMD;
                end
                SL_CMD: if (sl_g) begin
                    sl_cw_q <= sl_mem_rdata;
                    sa_q <= sl_ptr_q + `IPC_AW_STEP;
                    sl_st_q <= SL_ADW;
                end
                SL_ADW: if (sl_g) begin
                    sl_aw_q <= sl_mem_rdata;
                    sl_loc_q <= sa_q;
                    sl_ptr_q <= sl_ptr_q + `IPC_PW_STEP;
                    sl_st_q <= SL_WAIT;
                end
                SL_WAIT: if (sl_srv_req)
                    sl_st_q <= SL_EXEC;
                SL_EXEC: begin
                    sl_act_q <= sl_a;
                    sl_o_q <= {sl_a.dstb, seldev_q, sl_cw_q[`IPC_CW_ORD],
                               sl_cw_q[`IPC_CW_CNT], sl_aw_q, sl_a.last};
                    sa_q <= sl_a.addr;
                    sw_q <= sl_a.wdata;
                    swe_q <= sl_a.we;
                    sl_st_q <= sl_a.mem ? SL_MEM : SL_FIN;
                end
                SL_MEM: if (sl_g) begin
                    swe_q <= 1'b0;
                    if (sl_cw_q[`IPC_CW_ORD] == `IPC_ORD_WRITE)
                        sl_o_q <= {1'b1, seldev_q, sl_cw_q[`IPC_CW_ORD],
                                   sl_cw_q[`IPC_CW_CNT], sl_mem_rdata, sl_act_q.last};
                    sl_st_q <= SL_FIN;
                end
                SL_FIN: begin
                    if (sl_act_q.fin) begin
                        // hand the pointer back before going idle
                        sa_q <= sl_drt;
                        sw_q <= sl_ptr_q;
                        swe_q <= 1'b1;
                        sl_st_q <= SL_PTRW;
                    end else if (sl_act_q.jmp) begin
                        sl_ptr_q <= sl_aw_q;
                        sa_q <= sl_aw_q;
                        sl_st_q <= SL_CMD;
                    end else if (sl_act_q.refetch) begin
                        sa_q <= sl_ptr_q;
                        sl_st_q <= SL_CMD;
                    end else begin
                        sl_cw_q <= {sl_cw_q[`IPC_CW_TOP], sl_act_q.cnt};
                        sl_aw_q <= sl_aw_q + `IPC_AW_STEP;
                        sl_st_q <= SL_WAIT;
                    end
                end
                SL_PTRW: if (sl_g) begin
                    swe_q <= 1'b0;
                    sl_st_q <= SL_IDLE;
                end
                default: sl_st_q <= SL_IDLE;
            endcase
        end
    end
endmodule // ipc_channel

// *** logic/ipc_pkg.sv ***
package ipc_pkg;
    // memory request, held until granted
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ipc_mreq_s;
    // order strobe towards a controller
    typedef struct packed {
        logic        stb;
        logic [3:0]  dev;
        logic [2:0]  ord;
        logic [11:0] cnt;
        logic [15:0] word;
        logic        last;
    } ipc_ord_s;
    // answer from the addressed controller
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] status;
        logic        jump_ok;
    } ipc_dvi_s;
    // direct instruction towards a controller
    typedef struct packed {
        logic        stb;
        logic [2:0]  op;
        logic [3:0]  dev;
        logic [15:0] data;
    } ipc_dio_s;
    // decoded action of one order step
    typedef struct packed {
        logic        mem;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        jmp;
        logic        fin;
        logic        dstb;
        logic        last;
        logic        refetch;
        logic [11:0] cnt;
    } ipc_act_s;
    typedef enum logic [2:0] {
        MX_IDLE, MX_PTR, MX_CMD, MX_ADW, MX_PUPD, MX_EXEC, MX_MEM, MX_FIN
    } ipc_mx_e;
    typedef enum logic [3:0] {
        SL_IDLE, SL_PTR, SL_CMD, SL_ADW, SL_WAIT, SL_EXEC, SL_MEM, SL_FIN, SL_PTRW
    } ipc_sl_e;
endpackage

// *** logic/ipc_prio.sv ***
module ipc_prio (
    input  wire logic [15:0] req,
    output logic             any,
    output logic [3:0]       idx
);
    logic [16:0] seen;
    logic [3:0]  part [17];
    // ****************************************************************
    // fixed priority, lowest index wins
    // ****************************************************************
    assign seen[0] = 1'b0;
    assign part[0] = 4'h0;
    genvar i;
    for (i = 0; i < 16; i++) begin : g_pr
        assign seen[i+1] = seen[i] | req[i];
        assign part[i+1] = part[i] | ((req[i] && !seen[i]) ? 4'(i) : 4'h0);
    end
    assign any = seen[16];
    assign idx = part[16];
endmodule // ipc_prio

// *** verification/ipc_channel_asserts.sv ***
module ipc_channel_asserts (
    input wire logic               mclk,
    input wire logic               resetn,
    input wire logic               ce,
    input wire logic               reg_rd,
    input wire logic               iop_mem_gnt,
    input wire logic               sl_mem_gnt,
    input wire logic [15:0]        reg_rdata,
    input wire ipc_pkg::ipc_dio_s  dio_o,
    input wire ipc_pkg::ipc_mreq_s iop_mem_o,
    input wire ipc_pkg::ipc_mreq_s sl_mem_o,
    input wire ipc_pkg::ipc_ord_s  mx_o,
    input wire ipc_pkg::ipc_ord_s  sl_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import ipc_pkg::*;
    // ****
    // one clock domain
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_rd; ce && !reg_rd |=> reg_rdata == 16'h0000; endproperty
    a_rd: assert property (p_rd) else $error("read data without read");
    // a frozen clock enable holds a strobe, so only an enabled cycle counts
    property p_dio; dio_o.stb && ce |=> !dio_o.stb; endproperty
    a_dio: assert property (p_dio) else $error("direct strobe too long");
    // a request may not move before its grant
    property p_im; iop_mem_o.req && !iop_mem_gnt |=> iop_mem_o.req && $stable(iop_mem_o.addr);
    endproperty
    a_im: assert property (p_im) else $error("processor request dropped");
    property p_sm; sl_mem_o.req && !sl_mem_gnt |=> sl_mem_o.req && $stable(sl_mem_o.addr);
    endproperty
    a_sm: assert property (p_sm) else $error("selector request dropped");
    property p_ms; mx_o.stb && ce |=> !mx_o.stb; endproperty
    a_ms: assert property (p_ms) else $error("mux strobe too long");
    property p_ss; sl_o.stb && ce |=> !sl_o.stb; endproperty
    a_ss: assert property (p_ss) else $error("selector strobe too long");
    property p_ml; mx_o.stb && mx_o.ord < 3'h6 |-> mx_o.last; endproperty
    a_ml: assert property (p_ml) else $error("mux non-data order not last");
    property p_sl; sl_o.stb && sl_o.ord < 3'h6 |-> sl_o.last; endproperty
    a_sl: assert property (p_sl) else $error("selector non-data order not last");
    c_st: cover property (dio_o.stb && dio_o.op == 3'h6);
    c_end: cover property (mx_o.stb && mx_o.ord == 3'h3);
    c_rd: cover property (sl_o.stb && sl_o.ord == 3'h7);
endmodule // ipc_channel_asserts
bind ipc_channel ipc_channel_asserts u_ipc_channel_asserts (.mclk, .resetn, .ce, .reg_rd,
    .iop_mem_gnt, .sl_mem_gnt, .reg_rdata, .dio_o, .iop_mem_o, .sl_mem_o, .mx_o, .sl_o);

// *** verification/ipc_channel_tb.sv ***
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module ipc_channel_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ipc_pkg::*;
    logic mclk = 0, resetn = 0, ce = 1, reg_wr = 0, reg_rd = 0, ig = 0, sg = 0;
    logic cpu_irq, dio_ack, sl_srv_req;
    logic [3:0] reg_addr = 4'h0, cpu_irq_dev;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv, dev_irq, mx_srv_req, dio_rdata, mem [256];
    ipc_dio_s dio_o; ipc_mreq_s iop_mem_o, sl_mem_o; ipc_ord_s mx_o, sl_o; ipc_dvi_s mx_i, sl_i;
    int fail_count = 0, checks = 0, cyc = 0;
    ipc_channel u_ipc_channel (.mclk, .resetn, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cpu_irq, .cpu_irq_dev, .dev_irq, .dio_o, .dio_ack, .dio_rdata,
        .iop_mem_o, .iop_mem_gnt(ig), .iop_mem_rdata(ig ? mem[iop_mem_o.addr[7:0]] : 16'hDEAD),
        .mx_srv_req, .mx_o, .mx_i, .sl_mem_o, .sl_mem_gnt(sg), .sl_srv_req, .sl_o, .sl_i,
        .sl_mem_rdata(sg ? mem[sl_mem_o.addr[7:0]] : 16'hBEEF));
    ipc_dev_model u_ipc_dev_model (.mclk, .dio_o, .mx_o, .dio_ack, .dio_rdata, .dev_irq,
        .mx_srv_req, .sl_srv_req, .mx_i, .sl_i);
    initial forever #50 mclk = ~mclk;
    // memory grants one cycle after each request
    always @(posedge mclk) begin
        ig <= iop_mem_o.req & !ig;
        sg <= sl_mem_o.req & !sg;
        if (ig & iop_mem_o.we) mem[iop_mem_o.addr[7:0]] <= iop_mem_o.wdata;
        if (sg & sl_mem_o.we) mem[sl_mem_o.addr[7:0]] <= sl_mem_o.wdata;
    end
    always @(posedge mclk) if (++cyc == 20000) begin fail_count++; wrap_up(); end
    task wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge mclk) reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task rd(input logic [3:0] a);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk) reg_rd <= 1'b0;
        #1 rv = reg_rdata;
        @(posedge mclk);
    endtask
    task rc(input logic [3:0] a, input logic [15:0] e); rd(a); `CHK("reg_rdata", e, rv); endtask
    // launch, then poll busy and running flags with a bound
    task dio(input logic [6:0] c);
        wr(4'h0, {9'h000, c});
        repeat (40) begin
            rd(4'h0);
            if (rv[2:0] == 3'h0) begin rd(4'h5); if (rv == 16'h0000) break; end
        end
        `CHK("idle", 16'h0000, rv);
    endtask
    task wrap_up;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        mem = '{default: 16'h0000};
        mem[8'h14] = 16'h0060; mem[8'h63] = 16'h0070; mem[8'h70] = 16'h3000; mem[8'h08] = 16'h0040;
        {mem[8'h60], mem[8'h62], mem[8'h64], mem[8'h66]} = {16'h5000, 16'h0800, 16'h2000, 16'h3000};
        {mem[8'h40], mem[8'h41], mem[8'h42], mem[8'h43]} = {16'h4123, 16'hC0DE, 16'hFFFF, 16'h0080};
        {mem[8'h44], mem[8'h45], mem[8'h46]} = {16'h7FFF, 16'h0090, 16'h3000};
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        wr(4'hF, 16'hFFFF);
        for (int a = 0; a < 16; a++) rc(a[3:0], 16'h0000);
        // a write while the clock enable is low must leave no trace
        ce <= 1'b0;
        wr(4'h4, 16'h000F);
        ce <= 1'b1;
        rc(4'h4, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            if (i == 5) wr(4'h1, 16'h0030);
            dio({i[2:0], i[3:0]});
            if (i == 0 || i == 2) rc(4'h1, {12'hA50, i[3:0]});
        end
        rc(4'h2, 16'h0010);
        rc(4'h3, 16'h0030);
        `CHK("cpu_irq", 1'b1, cpu_irq);
        `CHK("cpu_irq_dev", 4'h4, cpu_irq_dev);
        wr(4'h2, 16'h0010);
        dio(7'h65);
        `CHK("sense", 16'h0C05, mem[8'h61]);
        `CHK("end", 16'h0C05, mem[8'h67]);
        `CHK("ptr", 16'h0068, mem[8'h14]);
        rc(4'h2, 16'h0020);
        `CHK("cpu_irq_dev", 4'h5, cpu_irq_dev);
        wr(4'h4, 16'h0002);
        dio(7'h62);
        `CHK("rd0", 16'h5678, mem[8'h80]);
        `CHK("rd1", 16'h5678, mem[8'h90]);
        `CHK("send", 16'h0C02, mem[8'h47]);
        wrap_up();
    end
endmodule // ipc_channel_tb

// *** verification/ipc_dev_model.sv ***
module ipc_dev_model (
    input  wire ipc_pkg::ipc_dio_s dio_o,
    input  wire ipc_pkg::ipc_ord_s mx_o,
    input  wire logic              mclk,
    output logic                   dio_ack,
    output logic                   sl_srv_req,
    output logic [15:0]            dio_rdata,
    output logic [15:0]            dev_irq,
    output logic [15:0]            mx_srv_req,
    output ipc_pkg::ipc_dvi_s      mx_i,
    output ipc_pkg::ipc_dvi_s      sl_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import ipc_pkg::*;
    logic [3:0] sh_q = 4'h0;
    logic [3:0] dev_q = 4'h0;
    // slow controller: ack four cycles after the strobe
    always @(posedge mclk) begin
        sh_q <= {sh_q[2:0], dio_o.stb};
        if (dio_o.stb) dev_q <= dio_o.dev;
    end
    assign dio_ack = sh_q[3];
    // data valid only with ack, inverse otherwise so stale values show
    assign dio_rdata = dio_ack ? {12'hA50, dev_q} : ~{12'hA50, dev_q};
    assign dev_irq = (mx_o.stb && mx_o.ord == 3'h2) ? 16'h0001 << mx_o.dev : 16'h0000;
    assign mx_srv_req = 16'h0020;
    assign sl_srv_req = 1'b1;
    assign mx_i = '{16'h1234, 16'h0C05, 1'b0};
    assign sl_i = '{16'h5678, 16'h0C02, 1'b1};
endmodule // ipc_dev_model
